// ===== verilog/dimm_cmd_pkg.sv
// Purpose: shared constants and types for the registered module command path
// Assumes: APB register map, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package dimm_cmd_pkg;
  localparam int ADDR_W = 14;
  localparam int BANKS = 4;
  localparam int RANKS = 2;
  localparam int DM_W = 9;
  localparam int PADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] CFG_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] ROW_OFF = 12'h008;

  // configuration fields
  localparam int CFG_CL_LSB = 0;
  localparam int CFG_AL_LSB = 4;
  localparam int CFG_BL8_BIT = 8;
  localparam int CFG_ILV_BIT = 9;
  localparam int CFG_PAR_BIT = 10;
  localparam logic [2:0] CL_RESET = 3'h3;
  localparam logic [2:0] AL_RESET = 3'h0;

  // status fields
  localparam int ST_OPEN_LSB = 0;
  localparam int ST_PWR_LSB = 8;
  localparam int ST_PERR_BIT = 16;
  localparam int ST_APEND_LSB = 17;
  localparam int ST_RUN_BIT = 19;

  // burst length in clocks, two beats per clock
  localparam logic [4:0] BURST4_CLKS = 5'h2;
  localparam logic [4:0] BURST8_CLKS = 5'h4;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_DESEL
  } cmd_t;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SELF_REF} pwr_t;
endpackage

// ===== verilog/dimm_cmd_path.sv
// Purpose: command, address and control register stage of a registered DDR2 module
// Assumes: host command pins are synchronous to pclk; module reset pin is not
// Notes: configuration, status and last row reachable over APB
//
// Summary of operation
// [RULE1] clock enable high runs DRAM clock
// [RULE2] clock enable low enters power-down or self-refresh
// [RULE3] rank select low enables that rank's decoder
// [RULE4] both selects high freeze all but cke/odt; code also forwards rank selects and clock run
// [RULE5] strobes sampled at rising edge select command
// [RULE6] two bank bits pick one of four banks
// [RULE7] address carries row on activate, column otherwise
// [RULE8] autoprecharge bit closes bank after burst
// [RULE9] precharge with autoprecharge bit closes all banks
// [RULE10] high mask bit blocks that byte's write
// [RULE11] mask and data gain one clock latency
// [RULE12] module reset forces outputs and clocks low
// [RULE13] host drives parity, one means odd
// [RULE14] parity mismatch is flagged on error output
// [RULE15] write latency equals read latency minus one
// [RULE16] host programs column latency three to five
// [RULE17] host adds additive latency zero to four
// [RULE18] bursts four or eight, sequential or interleaved
// [RULE19] host refreshes every 7.8us or 3.9us
// [RULE20] second rank pins only on two-rank modules
// [RULE21] termination control forwarded even when deselected
// [RULE22] inputs captured and presented one clock later
`timescale 1ns/1ps
module dimm_cmd_path (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic module_reset_n,
  input wire logic clock_enable_first_rank,
  input wire logic clock_enable_second_rank,
  input wire logic rank_select_first_n,
  input wire logic rank_select_second_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic [1:0] bank_addr,
  input wire logic [13:0] addr,
  input wire logic [8:0] data_mask,
  input wire logic [1:0] term_ctrl,
  input wire logic parity_in,
  output logic [1:0] dram_clock_run,
  output logic [1:0] dram_cke,
  output logic [1:0] dram_rank_select_n,
  output logic dram_row_strobe_n,
  output logic dram_column_strobe_n,
  output logic dram_write_enable_n,
  output logic [1:0] dram_bank_addr,
  output logic [13:0] dram_addr,
  output logic [1:0] dram_term_ctrl,
  output logic [8:0] dram_data_mask,
  output logic [8:0] byte_write_en,
  output logic parity_error,
  output logic [7:0] bank_open
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic dimm_cmd_pkg::cmd_t dec_cmd(input logic cs_n, input logic ras_n,
                                                 input logic cas_n, input logic we_n);
    dimm_cmd_pkg::cmd_t c;
    c = dimm_cmd_pkg::CMD_NOP;
    if (cs_n) c = dimm_cmd_pkg::CMD_DESEL;
    else begin
      case ({ras_n, cas_n, we_n})
        3'h3: c = dimm_cmd_pkg::CMD_ACT;
        3'h5: c = dimm_cmd_pkg::CMD_RD;
        3'h4: c = dimm_cmd_pkg::CMD_WR;
        3'h2: c = dimm_cmd_pkg::CMD_PRE;
        3'h1: c = dimm_cmd_pkg::CMD_REF;
        3'h0: c = dimm_cmd_pkg::CMD_MRS;
        default: c = dimm_cmd_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // module reset pin synchroniser; only the second stage is read
  logic rst_meta;
  logic mod_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {mod_run, rst_meta} <= 2'h0;
    else {mod_run, rst_meta} <= {rst_meta, module_reset_n};
  end

  // configuration
  logic [2:0] cas_lat;
  logic [2:0] add_lat;
  logic burst8;
  logic interleave;
  logic par_en;
  logic par_sticky;
  logic [13:0] last_row;

  wire access = psel && penable;
  wire wr_stb = access && pwrite;
  wire sel_cfg = paddr == dimm_cmd_pkg::CFG_OFF;
  wire sel_status = paddr == dimm_cmd_pkg::STATUS_OFF;
  wire sel_row = paddr == dimm_cmd_pkg::ROW_OFF;
  wire mapped = sel_cfg || sel_status || sel_row;

  // latencies in clocks; write latency is read latency less one
  wire [4:0] read_lat = {2'h0, add_lat} + {2'h0, cas_lat};
  wire [4:0] write_lat = read_lat - 5'h1; // [RULE15]
  wire [4:0] burst_clks = burst8 ? dimm_cmd_pkg::BURST8_CLKS : dimm_cmd_pkg::BURST4_CLKS; // [RULE18]

  // register stage
  wire both_desel = rank_select_first_n && rank_select_second_n;
  logic parity_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_clock_run <= 2'h0;
      dram_cke <= 2'h0;
      dram_rank_select_n <= 2'h0;
      dram_term_ctrl <= 2'h0;
    end else if (!mod_run) begin // [RULE12]
      dram_clock_run <= 2'h0;
      dram_cke <= 2'h0;
      dram_rank_select_n <= 2'h0;
      dram_term_ctrl <= 2'h0;
    end else begin
      dram_clock_run <= {clock_enable_second_rank, clock_enable_first_rank}; // [RULE1]
      dram_cke <= {clock_enable_second_rank, clock_enable_first_rank}; // [RULE2]
      dram_rank_select_n <= {rank_select_second_n, rank_select_first_n}; // [RULE3]
      dram_term_ctrl <= term_ctrl; // [RULE21]
    end
  end

  // held while both ranks are deselected, cutting switching on the DRAM bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_row_strobe_n <= 1'b0;
      dram_column_strobe_n <= 1'b0;
      dram_write_enable_n <= 1'b0;
      dram_bank_addr <= 2'h0;
      dram_addr <= 14'h0;
      dram_data_mask <= 9'h0;
      parity_q <= 1'b0;
    end else if (!mod_run) begin // [RULE12]
      dram_row_strobe_n <= 1'b0;
      dram_column_strobe_n <= 1'b0;
      dram_write_enable_n <= 1'b0;
      dram_bank_addr <= 2'h0;
      dram_addr <= 14'h0;
      dram_data_mask <= 9'h0;
      parity_q <= 1'b0;
    end else if (!both_desel) begin // [RULE4]
      dram_row_strobe_n <= row_strobe_n; // [RULE22]
      dram_column_strobe_n <= column_strobe_n;
      dram_write_enable_n <= write_enable_n;
      dram_bank_addr <= bank_addr;
      dram_addr <= addr; // [RULE7]
      dram_data_mask <= data_mask; // [RULE11]
      parity_q <= parity_in;
    end
  end

  // per-rank decode of what the DRAMs see
  dimm_cmd_pkg::cmd_t rank_cmd [2];
  assign rank_cmd[0] = dec_cmd(dram_rank_select_n[0], dram_row_strobe_n,
                               dram_column_strobe_n, dram_write_enable_n); // [RULE5]
  assign rank_cmd[1] = dec_cmd(dram_rank_select_n[1], dram_row_strobe_n,
                               dram_column_strobe_n, dram_write_enable_n);
  wire ap_bit = dram_addr[10];
  wire wr_go = rank_cmd[0] == dimm_cmd_pkg::CMD_WR || rank_cmd[1] == dimm_cmd_pkg::CMD_WR;

  // autoprecharge timers, one per rank; a later autoprecharge read or write replaces a pending one
  logic [4:0] ap_cnt [2];
  logic [1:0] ap_bank [2];
  logic [7:0] next_open;

  always_comb begin
    next_open = bank_open;
    for (int r = 0; r < 2; r++) begin
      if (ap_cnt[r] == 5'h1) next_open[r * 4 + int'(ap_bank[r])] = 1'b0; // [RULE8]
      case (rank_cmd[r])
        dimm_cmd_pkg::CMD_ACT: next_open[r * 4 + int'(dram_bank_addr)] = 1'b1; // [RULE6]
        dimm_cmd_pkg::CMD_PRE: begin
          if (ap_bit) next_open[r * 4 +: 4] = 4'h0; // [RULE9]
          else next_open[r * 4 + int'(dram_bank_addr)] = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_open <= 8'h0;
      for (int r = 0; r < 2; r++) begin
        ap_cnt[r] <= 5'h0;
        ap_bank[r] <= 2'h0;
      end
    end else if (!mod_run) begin
      bank_open <= 8'h0;
      for (int r = 0; r < 2; r++) ap_cnt[r] <= 5'h0;
    end else begin
      bank_open <= next_open;
      for (int r = 0; r < 2; r++) begin
        if ((rank_cmd[r] == dimm_cmd_pkg::CMD_RD || rank_cmd[r] == dimm_cmd_pkg::CMD_WR)
            && ap_bit) begin // [RULE8]
          ap_bank[r] <= dram_bank_addr;
          ap_cnt[r] <= (rank_cmd[r] == dimm_cmd_pkg::CMD_RD ? read_lat : write_lat)
                       + burst_clks;
        end else if (ap_cnt[r] != 5'h0) ap_cnt[r] <= ap_cnt[r] - 5'h1; // [RULE8]
      end
    end
  end

  // write data window after the write reaches the DRAMs
  logic [4:0] wr_cnt;
  wire wr_win = wr_cnt != 5'h0 && wr_cnt <= burst_clks;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_cnt <= 5'h0;
    else if (!mod_run) wr_cnt <= 5'h0;
    else if (wr_go) wr_cnt <= write_lat + burst_clks; // [RULE15]
    else if (wr_cnt != 5'h0) wr_cnt <= wr_cnt - 5'h1;
  end
  assign byte_write_en = {9{wr_win}} & ~dram_data_mask; // [RULE10]

  // power state per rank, judged on the clock enable falling edge
  dimm_cmd_pkg::pwr_t pwr [2];
  logic [1:0] cke_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cke_d <= 2'h0;
      for (int r = 0; r < 2; r++) pwr[r] <= dimm_cmd_pkg::PWR_ACTIVE;
    end else begin
      cke_d <= dram_cke;
      for (int r = 0; r < 2; r++) begin
        case (pwr[r])
          dimm_cmd_pkg::PWR_ACTIVE:
            if (cke_d[r] && !dram_cke[r]) begin // [RULE2]
              if (rank_cmd[r] == dimm_cmd_pkg::CMD_REF) pwr[r] <= dimm_cmd_pkg::PWR_SELF_REF;
              else pwr[r] <= dimm_cmd_pkg::PWR_DOWN;
            end
          dimm_cmd_pkg::PWR_DOWN,
          dimm_cmd_pkg::PWR_SELF_REF:
            if (dram_cke[r]) pwr[r] <= dimm_cmd_pkg::PWR_ACTIVE;
          default: pwr[r] <= dimm_cmd_pkg::PWR_ACTIVE;
        endcase
      end
    end
  end

  // parity over the registered address and control bus; parity bit one means odd
  wire bus_odd = ^{dram_addr, dram_bank_addr, dram_row_strobe_n,
                   dram_column_strobe_n, dram_write_enable_n};
  wire par_bad = par_en && mod_run && !(&dram_rank_select_n) && (bus_odd != parity_q); // [RULE14]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) parity_error <= 1'b0;
    else parity_error <= par_bad; // [RULE14]
  end

  // registers; sticky parity flag: a new error wins over a clear
  wire clr_perr = wr_stb && sel_status && pwdata[dimm_cmd_pkg::ST_PERR_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cas_lat <= dimm_cmd_pkg::CL_RESET;
      add_lat <= dimm_cmd_pkg::AL_RESET;
      burst8 <= 1'b0;
      interleave <= 1'b0;
      par_en <= 1'b0;
      par_sticky <= 1'b0;
      last_row <= 14'h0;
    end else begin
      if (wr_stb && sel_cfg) begin
        cas_lat <= pwdata[dimm_cmd_pkg::CFG_CL_LSB +: 3];
        add_lat <= pwdata[dimm_cmd_pkg::CFG_AL_LSB +: 3];
        burst8 <= pwdata[dimm_cmd_pkg::CFG_BL8_BIT];
        interleave <= pwdata[dimm_cmd_pkg::CFG_ILV_BIT];
        par_en <= pwdata[dimm_cmd_pkg::CFG_PAR_BIT];
      end
      if (par_bad) par_sticky <= 1'b1;
      else if (clr_perr) par_sticky <= 1'b0;
      if (rank_cmd[0] == dimm_cmd_pkg::CMD_ACT || rank_cmd[1] == dimm_cmd_pkg::CMD_ACT)
        last_row <= dram_addr; // [RULE7]
    end
  end

  logic [31:0] cfg_word;
  logic [31:0] status_word;
  always_comb begin
    cfg_word = 32'h0;
    cfg_word[dimm_cmd_pkg::CFG_CL_LSB +: 3] = cas_lat;
    cfg_word[dimm_cmd_pkg::CFG_AL_LSB +: 3] = add_lat;
    cfg_word[dimm_cmd_pkg::CFG_BL8_BIT] = burst8;
    cfg_word[dimm_cmd_pkg::CFG_ILV_BIT] = interleave;
    cfg_word[dimm_cmd_pkg::CFG_PAR_BIT] = par_en;
    status_word = 32'h0;
    status_word[dimm_cmd_pkg::ST_OPEN_LSB +: 8] = bank_open;
    status_word[dimm_cmd_pkg::ST_PWR_LSB +: 2] = pwr[0];
    status_word[dimm_cmd_pkg::ST_PWR_LSB + 2 +: 2] = pwr[1];
    status_word[dimm_cmd_pkg::ST_PERR_BIT] = par_sticky;
    status_word[dimm_cmd_pkg::ST_APEND_LSB] = ap_cnt[0] != 5'h0;
    status_word[dimm_cmd_pkg::ST_APEND_LSB + 1] = ap_cnt[1] != 5'h0;
    status_word[dimm_cmd_pkg::ST_RUN_BIT] = mod_run;
  end

  wire [31:0] rd_mux = sel_cfg ? cfg_word : sel_status ? status_word
                     : sel_row ? {18'h0, last_row} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // checks
  sequence s_act_rank0;
    rank_cmd[0] == dimm_cmd_pkg::CMD_ACT && mod_run;
  endsequence
  sequence s_pre_all_rank0;
    rank_cmd[0] == dimm_cmd_pkg::CMD_PRE && ap_bit && ap_cnt[0] == 5'h0 && mod_run;
  endsequence

  a_reg_addr_delay: assert property ( // [RULE22]
    mod_run && !both_desel ##1 mod_run |-> dram_addr == $past(addr) &&
      dram_bank_addr == $past(bank_addr))
    else $error("address not presented one clock after capture");
  a_desel_hold: assert property ( // [RULE4]
    mod_run && both_desel ##1 mod_run |-> $stable(dram_addr) && $stable(dram_data_mask))
    else $error("outputs changed while both ranks deselected");
  a_odt_forward: assert property ( // [RULE21]
    mod_run ##1 mod_run |-> dram_term_ctrl == $past(term_ctrl))
    else $error("termination control not forwarded");
  a_reset_low: assert property ( // [RULE12]
    !mod_run |=> dram_addr == 14'h0 && dram_clock_run == 2'h0 && dram_cke == 2'h0)
    else $error("outputs not low during module reset");
  a_clock_gate: assert property ( // [RULE1]
    mod_run && !clock_enable_first_rank |=> !dram_clock_run[0])
    else $error("dram clock running with clock enable low");
  a_act_opens: assert property ( // [RULE6]
    s_act_rank0 |=> bank_open[$past(dram_bank_addr)])
    else $error("activate did not open bank");
  a_pre_all: assert property ( // [RULE9]
    s_pre_all_rank0 |=> bank_open[3:0] == 4'h0)
    else $error("precharge all left a bank open");
  a_parity_flag: assert property ( // [RULE14]
    par_en && mod_run && !dram_rank_select_n[0] && bus_odd != parity_q |=> parity_error)
    else $error("parity mismatch not flagged");
  a_mask_block: assert property ( // [RULE10]
    wr_win |-> (byte_write_en & dram_data_mask) == 9'h0 && byte_write_en == ~dram_data_mask)
    else $error("masked byte enabled for write");
  a_write_window: assert property ( // [RULE15]
    wr_go && mod_run |=> wr_cnt == $past(read_lat) - 5'h1 + $past(burst_clks))
    else $error("write window not one less than read latency");
  a_ap_timer: assert property ( // [RULE8]
    mod_run && rank_cmd[0] == dimm_cmd_pkg::CMD_RD && ap_bit |=> ap_cnt[0] != 5'h0)
    else $error("autoprecharge not scheduled");
  a_self_ref: assert property ( // [RULE2]
    pwr[0] == dimm_cmd_pkg::PWR_ACTIVE && cke_d[0] && !dram_cke[0] &&
      rank_cmd[0] == dimm_cmd_pkg::CMD_REF |=> pwr[0] == dimm_cmd_pkg::PWR_SELF_REF)
    else $error("self refresh not entered");

endmodule

// ===== testbench/host_ctrl_model.sv
// Purpose: host memory controller model driving the module's command pins
// Assumes: every change lands just after a rising pclk edge
// Notes: the idle bus is deselected with inverted address, so stale values never look valid
`timescale 1ns/1ps
module host_ctrl_model (
  input wire logic pclk,
  output logic [1:0] cke,
  output logic [1:0] sel_n,
  output logic [2:0] rcw,
  output logic [1:0] ba,
  output logic [13:0] a,
  output logic [8:0] dm,
  output logic [1:0] odt,
  output logic par
);
  logic bad_par;
  initial begin
    cke = 2'b11;
    sel_n = 2'b11;
    rcw = 3'b111;
    ba = 2'h0;
    a = 14'h0000;
    dm = 9'h000;
    odt = 2'h0;
    par = 1'b0;
    bad_par = 1'b0;
  end
  // bad_par breaks parity on purpose, only when the bench asks for it
  task automatic drive(input logic [2:0] c, input logic [1:0] s, input logic [1:0] b,
      input logic [13:0] ad, input logic [1:0] o);
    @(posedge pclk);
    rcw <= c;
    sel_n <= s;
    ba <= b;
    a <= ad;
    odt <= o;
    par <= (^{ad, b, c}) ^ bad_par;
  endtask
  task automatic idle();
    drive(3'b111, 2'b11, ~ba, ~a, odt);
  endtask
  task automatic set_dm(input logic [8:0] m);
    dm <= m;
  endtask
  task automatic set_cke(input logic [1:0] k);
    cke <= k;
  endtask
  task automatic set_bad_par(input logic b);
    bad_par = b;
  endtask
  // runs are far shorter than one refresh interval, so one refresh per run is enough
  task automatic refresh(input logic [1:0] s);
    drive(3'b001, s, ba, a, odt);
  endtask
endmodule

// ===== testbench/testbench.sv
// Purpose: self-checking bench for the registered module command path
// Assumes: zero-wait APB slave, command outputs one clock behind the pins
// Notes: write window timing is taken from the column latency in the config word
`timescale 1ns/1ps
module testbench;
  localparam logic [2:0] ACT = 3'b011;
  localparam logic [2:0] RD = 3'b101;
  localparam logic [2:0] WR = 3'b100;
  localparam logic [2:0] PRE = 3'b010;
  logic pclk, presetn, psel, penable, pwrite, module_reset_n, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic parity_error, par, ras_n, cas_n, we_n;
  logic [1:0] cke, sel_n, ba, odt, clk_run, d_cke, d_sel_n, d_ba, d_odt;
  logic [2:0] rcw;
  logic [13:0] a, d_a;
  logic [8:0] dm, d_dm, byte_write_en;
  logic [7:0] bank_open;
  int failures, checks, cycles, n, first;
  host_ctrl_model host (.pclk(pclk), .cke(cke), .sel_n(sel_n), .rcw(rcw), .ba(ba), .a(a),
    .dm(dm), .odt(odt), .par(par));
  dimm_cmd_path dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .module_reset_n(module_reset_n), .clock_enable_first_rank(cke[0]),
    .clock_enable_second_rank(cke[1]), .rank_select_first_n(sel_n[0]),
    .rank_select_second_n(sel_n[1]), .row_strobe_n(rcw[2]), .column_strobe_n(rcw[1]),
    .write_enable_n(rcw[0]), .bank_addr(ba), .addr(a), .data_mask(dm), .term_ctrl(odt),
    .parity_in(par), .dram_clock_run(clk_run), .dram_cke(d_cke), .dram_rank_select_n(d_sel_n),
    .dram_row_strobe_n(ras_n), .dram_column_strobe_n(cas_n), .dram_write_enable_n(we_n),
    .dram_bank_addr(d_ba), .dram_addr(d_a), .dram_term_ctrl(d_odt), .dram_data_mask(d_dm),
    .byte_write_en(byte_write_en), .parity_error(parity_error), .bank_open(bank_open));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // generous ceiling, the full run needs about 160 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, x, g);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string w, input logic [11:0] ad, input logic [31:0] m,
      input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    check(w, x, rd & m);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [1:0] s, input logic [1:0] b,
      input logic [13:0] ad, input logic [1:0] o);
    host.drive(c, s, b, ad, o);
    host.idle();
    #1;
  endtask
  task automatic s_regs();
    rchk("cfg", dimm_cmd_pkg::CFG_OFF, 32'hffffffff, 32'h3);
    rchk("status", dimm_cmd_pkg::STATUS_OFF, 32'hffffffff, 32'h80000);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped err", 32'h1, 32'(e));
    check("unmapped data", 32'h0, rd);
    apb(1'b1, dimm_cmd_pkg::CFG_OFF, 32'h403);
    rchk("cfg back", dimm_cmd_pkg::CFG_OFF, 32'h7ff, 32'h403);
  endtask
  task automatic s_act();
    cmd(ACT, 2'b10, 2'h2, 14'h2a5c, 2'b01);
    check("act cmd", 32'(ACT), 32'({ras_n, cas_n, we_n}));
    check("act row", 32'h2a5c, 32'(d_a));
    check("act sel", 32'h2, 32'(d_sel_n));
    check("no perr", 32'h0, 32'(parity_error));
    step(1);
    check("open", 32'h04, 32'(bank_open));
    apb(1'b1, dimm_cmd_pkg::ROW_OFF, 32'h1234);
    rchk("row", dimm_cmd_pkg::ROW_OFF, 32'h3fff, 32'h2a5c);
    cmd(ACT, 2'b01, 2'h1, 14'h0123, 2'b00);
    step(1);
    check("open two", 32'h24, 32'(bank_open));
    cmd(RD, 2'b11, 2'h0, 14'h3fff, 2'b11);
    check("held addr", 32'h0123, 32'(d_a));
    check("odt passes", 32'h3, 32'(d_odt));
  endtask
  task automatic s_pre();
    cmd(PRE, 2'b01, 2'h0, 14'h0400, 2'b00);
    step(1);
    check("pre all", 32'h04, 32'(bank_open));
    cmd(PRE, 2'b10, 2'h3, 14'h0000, 2'b00);
    step(1);
    check("pre other", 32'h04, 32'(bank_open));
    cmd(PRE, 2'b10, 2'h2, 14'h0000, 2'b00);
    step(1);
    check("pre one", 32'h00, 32'(bank_open));
    host.refresh(2'b00);
    host.idle();
    #1;
    check("ref cmd", 32'h1, 32'({ras_n, cas_n, we_n}));
    step(1);
    check("ref keeps", 32'h00, 32'(bank_open));
  endtask
  task automatic s_ap();
    cmd(ACT, 2'b10, 2'h1, 14'h0055, 2'b00);
    cmd(RD, 2'b10, 2'h1, 14'h0000, 2'b00);
    step(10);
    check("no ap", 32'h02, 32'(bank_open));
    cmd(RD, 2'b10, 2'h1, 14'h0400, 2'b00);
    step(2);
    check("ap waits", 32'h02, 32'(bank_open));
    step(8);
    check("ap closed", 32'h00, 32'(bank_open));
  endtask
  task automatic s_wr();
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, dimm_cmd_pkg::CFG_OFF, 32'h403 + 32'(i * 257));
      host.set_dm(9'h0a5);
      cmd(ACT, 2'b10, 2'h0, 14'h0001, 2'b00);
      check("mask late", 32'h0a5, 32'(d_dm));
      cmd(WR, 2'b10, 2'h0, 14'h0008, 2'b00);
      n = 0;
      first = 0;
      for (int k = 1; k < 13; k++) begin
        step(1);
        if (byte_write_en !== 9'h000) begin
          n++;
          if (n == 1) first = k;
          check("bytes", 32'h15a, 32'(byte_write_en));
        end
      end
      check("beats", 32'(2 + 2 * i), 32'(n));
      check("write latency", 32'(3 + i), 32'(first));
      host.set_dm(9'h000);
    end
  endtask
  task automatic s_par();
    host.set_bad_par(1'b1);
    cmd(3'b111, 2'b10, 2'h0, 14'h0f0f, 2'b00);
    host.set_bad_par(1'b0);
    step(1);
    check("perr", 32'h1, 32'(parity_error));
    step(1);
    check("perr pulse", 32'h0, 32'(parity_error));
    rchk("perr sticky", dimm_cmd_pkg::STATUS_OFF, 32'h10000, 32'h10000);
    apb(1'b1, dimm_cmd_pkg::STATUS_OFF, 32'h10000);
    rchk("perr clear", dimm_cmd_pkg::STATUS_OFF, 32'h10000, 32'h0);
  endtask
  task automatic s_pwr();
    host.set_cke(2'b10);
    step(3);
    check("clock stop", 32'h2, 32'(clk_run));
    host.drive(3'b001, 2'b01, 2'h0, 14'h0000, 2'b00);
    host.set_cke(2'b00);
    host.idle();
    step(3);
    rchk("power", dimm_cmd_pkg::STATUS_OFF, 32'hf00, 32'h900);
    host.set_cke(2'b11);
    step(3);
    rchk("awake", dimm_cmd_pkg::STATUS_OFF, 32'hf00, 32'h0);
  endtask
  task automatic s_mrst();
    module_reset_n <= 1'b0;
    step(4);
    check("rst clk", 32'h0, 32'(clk_run));
    check("rst cke", 32'h0, 32'(d_cke));
    check("rst banks", 32'h0, 32'(bank_open));
    check("rst addr", 32'h0, 32'({d_a, d_ba, d_dm}));
    module_reset_n <= 1'b1;
    step(6);
    check("run again", 32'h3, 32'(clk_run));
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    module_reset_n = 1'b1;
    failures = 0;
    checks = 0;
    cycles = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    step(4);
    s_regs();
    s_act();
    s_pre();
    s_ap();
    s_wr();
    s_par();
    s_pwr();
    s_mrst();
    stop_test();
  end
endmodule
